/* File: hw/crr_top.sv */
/*
  Configuration control: readback, reprogram on the done pin, done timing
  and master parallel loading with chain forwarding.
  Assumes pins arrive asynchronously; open-drain level resolved outside.
*/
`include "crr_map.svh"

module crr_top #(
  parameter int                    FRAME_BITS  = 8,
  parameter int                    NUM_FRAMES  = 4,
  parameter logic [FRAME_BITS-1:0] USED_MASK   = 8'h3F,
  parameter int                    PRE_BYTES   = 2,
  parameter int                    LOAD_BYTES  = 10,
  parameter int                    TGEN_DIV    = 8,
  parameter int                    CLEAR_TICKS = 16,
  parameter int                    CONFIG_CLOCK_HALF   = 4
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  // Readback mode pins
  input  wire logic                    read_trigger_pin_i,
  output logic                         readback_data_pin_o,
  output logic                         readback_active_o,
  // Configuration clock pin
  input  wire logic                    config_clock_i,
  output logic                         config_clock_o,
  output logic                         config_clock_oe_n_o,
  // Done / program pin
  input  wire logic                    done_program_pin_i,
  output logic                         done_program_pin_o,
  output logic                         done_program_pin_oe_n_o,
  output logic                         done_pullup_en_o,
  // Initialisation and hold-off
  output logic                         init_done_o,
  input  wire logic                    hold_off_n_i,
  // Parallel ROM and chain
  output logic [`CRR_ADDR_W-1:0]       rom_address_out_o,
  output logic                         rom_addr_oe_n_o,
  input  wire logic [`CRR_BYTE_BITS-1:0] rom_data_i,
  output logic                         chain_data_o,
  // User pin control
  output logic                         user_out_en_o,
  output logic                         weak_pullup_o,
  // Configuration options
  input  wire logic [1:0]              readback_perm_i,
  input  wire logic                    done_early_i,
  input  wire logic                    pullup_opt_i,
  input  wire logic                    addr_down_i,
  // Live storage element state
  input  wire logic [FRAME_BITS-1:0]   live_state_i
);

  localparam int MEM_BITS  = FRAME_BITS * NUM_FRAMES;
  localparam int OWN_BYTES = MEM_BITS / `CRR_BYTE_BITS;
  localparam int PW        = $clog2(FRAME_BITS + 3);
  localparam int FW        = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1;
  localparam int BW        = $clog2(LOAD_BYTES + 2);
  localparam int TW        = (TGEN_DIV > 1) ? $clog2(TGEN_DIV) : 1;
  localparam int CTW       = (CLEAR_TICKS > 1) ? $clog2(CLEAR_TICKS) : 1;
  localparam int CW        = (CONFIG_CLOCK_HALF > 1) ? $clog2(CONFIG_CLOCK_HALF) : 1;

  typedef struct packed {
    crr_pkg::crr_state_t    st;
    logic [`CRR_SYN_W-1:0]  s1;
    logic [`CRR_SYN_W-1:0]  s2;
    logic [`CRR_SYN_W-1:0]  s3;
    logic [`CRR_SYN_W-1:0]  lvl;
    logic [TW-1:0]          tdiv;
    logic                   farm;
    logic [1:0]             ftick;
    logic [CTW-1:0]         clr;
    logic [CW-1:0]          cdiv;
    logic                   config_clock;
    logic [MEM_BITS-1:0]    mem;
    logic                   rb_used;
    logic [1:0]             dum;
    logic [PW-1:0]          pos;
    logic [FW-1:0]          frm;
    logic                   rb_out;
    logic [`CRR_ADDR_W-1:0] addr;
    logic [2:0]             sub;
    logic [BW-1:0]          bidx;
    logic                   step;
    logic                   done_drv;
    logic                   uout;
  } crr_core_st_t;

  crr_core_st_t          r;
  crr_core_st_t          n;
  logic [`CRR_SYN_W-1:0] rise;
  logic [`CRR_SYN_W-1:0] fall;
  logic                  tick;
  logic                  crise;
  logic                  cfall;
  logic                  cap;
  logic                  own;
  logic                  perm_ok;
  logic                  req;
  int                    bi;
  int                    wi;

  crr_ser_if ser ();

  crr_serializer u_ser (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ser    (ser)
  );

  assign ser.rise = crise;
  assign ser.fall = cfall;
  assign ser.load = cap;
  assign ser.fwd  = ~own; // R20
  assign ser.data = rom_data_i;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    bi = 0;
    wi = 0;
    n.s1 = {hold_off_n_i, config_clock_i, done_program_pin_i, read_trigger_pin_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // A level counts only once the last two stages agree
    for (int i = 0; i < `CRR_SYN_W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.lvl[i] = r.s3[i];
      end
    end
    rise = n.lvl & ~r.lvl;
    fall = ~n.lvl & r.lvl;

    tick   = (r.tdiv == '0);
    n.tdiv = (r.tdiv == TW'(TGEN_DIV - 1)) ? '0 : r.tdiv + TW'(1);

    // Generated clock only while this end loads the chain
    crise = 1'b0;
    cfall = 1'b0;
    if (r.st == crr_pkg::ST_LOAD || r.st == crr_pkg::ST_FINISH) begin
      n.cdiv = (r.cdiv == CW'(CONFIG_CLOCK_HALF - 1)) ? '0 : r.cdiv + CW'(1);
      if (r.cdiv == CW'(CONFIG_CLOCK_HALF - 1)) begin
        n.config_clock = ~r.config_clock;
        crise  = ~r.config_clock;
        cfall  = r.config_clock;
      end
    end else begin
      n.cdiv = '0;
      n.config_clock = 1'b0;
    end

    case (crr_pkg::crr_perm_t'(readback_perm_i)) // R1
      crr_pkg::PERM_ALWAYS: perm_ok = 1'b1;
      crr_pkg::PERM_ONCE:   perm_ok = ~r.rb_used;
      default:              perm_ok = 1'b0;
    endcase

    req = r.farm && !r.lvl[`CRR_SYN_DONE] && tick &&
          r.ftick == 2'(`CRR_FILTER_TICKS - 1); // R11
    cap = 1'b0;
    own = 1'b0;

    case (r.st)
      crr_pkg::ST_CLEAR: begin
        n.mem      = '0; // R13
        n.done_drv = 1'b1; // R15
        n.uout     = 1'b0; // R12
        if (tick) begin
          n.clr = r.clr + CTW'(1);
          if (r.clr == CTW'(CLEAR_TICKS - 1)) begin
            n.st = crr_pkg::ST_WAIT_HOLD;
          end
        end
      end
      crr_pkg::ST_WAIT_HOLD: begin
        // Followers still clearing keep this line low
        if (r.lvl[`CRR_SYN_HOLD]) begin // R14
          n.st   = crr_pkg::ST_LOAD;
          n.addr = addr_down_i ? `CRR_ADDR_DN_START : `CRR_ADDR_UP_START; // R23
          n.sub  = 3'h0;
          n.bidx = '0;
        end
      end
      crr_pkg::ST_LOAD: begin
        if (crise) begin
          n.sub = r.sub + 3'h1;
          if (r.sub == 3'h0) begin
            n.bidx = r.bidx + BW'(1);
            if (int'(r.bidx) < LOAD_BYTES) begin
              cap    = 1'b1; // R19
              n.addr = addr_down_i ? r.addr - 16'h0001 : r.addr + 16'h0001;
              own    = int'(r.bidx) >= PRE_BYTES && int'(r.bidx) < PRE_BYTES + OWN_BYTES;
              if (own) begin
                wi = (int'(r.bidx) - PRE_BYTES) * `CRR_BYTE_BITS;
                n.mem[wi +: `CRR_BYTE_BITS] = rom_data_i;
              end
            end
            // One spare byte period lets the last byte leave the chain
            if (int'(r.bidx) == LOAD_BYTES + 1) begin
              n.st   = crr_pkg::ST_FINISH;
              n.step = 1'b0;
            end
          end
        end
      end
      crr_pkg::ST_FINISH: begin
        if (crise) begin
          if (!r.step) begin
            n.step = 1'b1;
            if (done_early_i) begin // R18
              n.done_drv = 1'b0;
            end else begin
              n.uout = 1'b1;
            end
          end else begin
            n.done_drv = 1'b0;
            n.uout     = 1'b1;
            n.st       = crr_pkg::ST_OPER; // R16
            n.farm     = 1'b0;
          end
        end
      end
      crr_pkg::ST_OPER: begin
        // Fresh edge needed: a pin held low from outside is no new request
        if (fall[`CRR_SYN_DONE]) begin
          n.farm  = 1'b1;
          n.ftick = 2'h0;
        end else if (r.farm && r.lvl[`CRR_SYN_DONE]) begin
          n.farm = 1'b0;
        end else if (r.farm && tick) begin
          n.ftick = r.ftick + 2'h1;
        end
        if (req) begin
          n.st       = crr_pkg::ST_CLEAR; // R12
          n.done_drv = 1'b1; // R15
          n.uout     = 1'b0;
          n.clr      = '0;
          n.farm     = 1'b0;
          n.rb_used  = 1'b0;
        end else if (rise[`CRR_SYN_TRIG] && perm_ok) begin
          n.st  = crr_pkg::ST_READBACK; // R2
          n.dum = 2'h0;
          n.pos = '0;
          n.frm = '0;
        end
      end
      crr_pkg::ST_READBACK: begin
        // Host-driven clock; user outputs stay as they are
        if (rise[`CRR_SYN_CONFIG_CLOCK]) begin // R3 R5
          if (r.dum < 2'(`CRR_DUMMY_BITS - 1)) begin
            n.dum    = r.dum + 2'h1;
            n.rb_out = `CRR_DUMMY_VAL; // R4
          end else if (r.pos == '0) begin
            n.rb_out = `CRR_START_VAL; // R7
            n.pos    = PW'(1);
          end else if (int'(r.pos) <= FRAME_BITS) begin
            bi = int'(r.pos) - 1;
            if (USED_MASK[bi]) begin
              n.rb_out = ~r.mem[int'(r.frm) * FRAME_BITS + bi]; // R6
            end else begin
              n.rb_out = ~live_state_i[bi]; // R9
            end
            n.pos = r.pos + PW'(1);
          end else if (int'(r.pos) == FRAME_BITS + 1) begin
            n.rb_out = `CRR_STOP_VAL; // R7
            if (int'(r.frm) == NUM_FRAMES - 1) begin
              n.pos = r.pos + PW'(1);
            end else begin
              n.pos = '0;
              n.frm = r.frm + FW'(1);
            end
          end else begin
            n.st      = crr_pkg::ST_OPER; // R8
            n.rb_used = 1'b1; // R1
          end
        end
      end
      default: begin
        n.st = crr_pkg::ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r          <= '0;
      r.st       <= crr_pkg::ST_CLEAR;
      r.done_drv <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign readback_active_o       = (r.st == crr_pkg::ST_READBACK);
  assign readback_data_pin_o     = r.rb_out;
  assign config_clock_o          = r.config_clock;
  assign config_clock_oe_n_o     = ~(r.st == crr_pkg::ST_LOAD || r.st == crr_pkg::ST_FINISH);
  assign done_program_pin_o      = 1'b0;
  assign done_program_pin_oe_n_o = ~r.done_drv; // R17
  assign done_pullup_en_o        = pullup_opt_i; // R17
  assign init_done_o             = (r.st != crr_pkg::ST_CLEAR);
  assign rom_address_out_o       = r.addr;
  assign rom_addr_oe_n_o         = (r.st != crr_pkg::ST_LOAD); // R23
  assign chain_data_o            = ser.dout;
  assign user_out_en_o           = r.uout;
  assign weak_pullup_o           = ~r.uout; // R12

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RB_REFUSED: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
    r.st == crr_pkg::ST_OPER && rise[`CRR_SYN_TRIG] && !perm_ok
    |=> r.st != crr_pkg::ST_READBACK)
    else $error("readback started without permission");

  AST_RB_START: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
    r.st == crr_pkg::ST_OPER && rise[`CRR_SYN_TRIG] && perm_ok && !req
    |=> r.st == crr_pkg::ST_READBACK ##0 readback_active_o)
    else $error("trigger edge did not start readback");

  AST_START_THIRD: assert property (@(posedge clk_i) disable iff (!rstn_i) // R7
    r.st == crr_pkg::ST_READBACK && rise[`CRR_SYN_CONFIG_CLOCK] && r.pos == '0 &&
    r.dum == 2'(`CRR_DUMMY_BITS - 1) |=> readback_data_pin_o == 1'b1)
    else $error("third dummy bit is not a start bit of one");

  AST_STOP_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i) // R7
    r.st == crr_pkg::ST_READBACK && rise[`CRR_SYN_CONFIG_CLOCK] &&
    int'(r.pos) == FRAME_BITS + 1 |=> readback_data_pin_o == 1'b0)
    else $error("stop bit not returned as zero");

  AST_CLEARED: assert property (@(posedge clk_i) disable iff (!rstn_i) // R13
    r.st == crr_pkg::ST_CLEAR |=> r.mem == '0 && !init_done_o || r.st != crr_pkg::ST_CLEAR)
    else $error("memory not erased during clear");

  AST_DONE_HELD: assert property (@(posedge clk_i) disable iff (!rstn_i) // R15
    r.st inside {crr_pkg::ST_CLEAR, crr_pkg::ST_WAIT_HOLD, crr_pkg::ST_LOAD}
    |-> !done_program_pin_oe_n_o && !user_out_en_o && weak_pullup_o)
    else $error("done pin released or outputs on before load end");

  AST_OPER_ANYWAY: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
    r.st == crr_pkg::ST_FINISH && r.step && crise
    |=> r.st == crr_pkg::ST_OPER && done_program_pin_oe_n_o)
    else $error("operation did not begin at configuration end");

  AST_DONE_EARLY: assert property (@(posedge clk_i) disable iff (!rstn_i) // R18
    $rose(user_out_en_o) && done_early_i |-> $past(done_program_pin_oe_n_o))
    else $error("early done not ahead of outputs");

  AST_DONE_LATE: assert property (@(posedge clk_i) disable iff (!rstn_i) // R18
    $rose(user_out_en_o) && !done_early_i |-> !done_program_pin_oe_n_o)
    else $error("late done released with outputs");

  AST_FILTERED: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
    r.st == crr_pkg::ST_CLEAR && $past(r.st) == crr_pkg::ST_OPER
    |-> $past(r.farm) && !$past(r.lvl[`CRR_SYN_DONE]))
    else $error("reprogram without a filtered low request");

  AST_ADDR_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i) // R19
    cap |=> rom_address_out_o == ($past(addr_down_i) ? $past(r.addr) - 16'h0001
                                                      : $past(r.addr) + 16'h0001))
    else $error("address did not step after byte capture");

endmodule

/* File: hw/crr_map.svh */
/*
  Constants of the configuration readback / reprogram / master parallel block.
  Assumes inclusion by bare name from every design file of the block.
*/
// Overview of operation
// R1: Readback permission: never, once, or unlimited.
// R2: Trigger rising edge starts readback; host clocks.
// R3: Readback uses only mode and clock pins.
// R4: First three clock rises give dummy bits.
// R5: Each later rise shifts one frame bit.
// R6: Returned bits are inverted stored bits.
// R7: Start bit one, stop bit zero; third dummy starts.
// R8: Pins return to normal after last frame.
// R9: Empty positions carry live storage element state.
// R10: Host should stop system clock for snapshot.
// R11: Reprogram: falling edge stable two generator ticks.
// R12: Reprogram disables outputs, enables weak pull-ups.
// R13: Clear state erases memory before initialized.
// R14: Follower init lines hold lead in reset.
// R15: Device drives done pin low until loaded.
// R16: Operate on completion despite external low.
// R17: Done pin open-drain, optional pull-up, shareable.
// R18: Done one clock before or after outputs.
// R19: Capture ROM byte just before address step.
// R20: Serialize bytes; preamble and overflow to chain.
// R21: Byte LSB on chain 1.5 clocks after capture.
// R22: Chain changes on falling, sampled on rising.
// R23: Sixteen-bit ROM address, user pins afterwards.
`ifndef CRR_MAP_SVH
`define CRR_MAP_SVH

// ----------------------------------------------------------------------
// Stream and bus widths
// ----------------------------------------------------------------------
`define CRR_BYTE_BITS     8
`define CRR_ADDR_W        16
`define CRR_ADDR_UP_START 16'h0000
`define CRR_ADDR_DN_START 16'hFFFF

// ----------------------------------------------------------------------
// Readback framing
// ----------------------------------------------------------------------
`define CRR_DUMMY_BITS    3
`define CRR_DUMMY_VAL     1'b1
`define CRR_START_VAL     1'b1
`define CRR_STOP_VAL      1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CRR_FILTER_TICKS  2
`define CRR_LSB_FALLS     2
`define CRR_CHAIN_IDLE    1'b1

// ----------------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------------
`define CRR_SYN_W         4
`define CRR_SYN_TRIG      0
`define CRR_SYN_DONE      1
`define CRR_SYN_CONFIG_CLOCK      2
`define CRR_SYN_HOLD      3

`endif

/* File: hw/crr_pkg.sv */
/*
  Types of the configuration control block.
  Assumes crr_map.svh is on the include path.
*/
`include "crr_map.svh"

package crr_pkg;

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_WAIT_HOLD,
    ST_LOAD,
    ST_FINISH,
    ST_OPER,
    ST_READBACK
  } crr_state_t;

  typedef enum logic [1:0] {
    PERM_NEVER,
    PERM_ONCE,
    PERM_ALWAYS
  } crr_perm_t;

  typedef struct packed {
    logic [`CRR_BYTE_BITS-1:0] pend;
    logic                      pfwd;
    logic                      pval;
    logic                      page;
    logic [`CRR_BYTE_BITS-1:0] sh;
    logic                      sfwd;
    logic                      dout;
  } crr_ser_st_t;

endpackage

/* File: hw/crr_ser_if.sv */
/*
  Link between the control core and the chain serializer.
  Assumes both ends run on the same system clock.
*/
`include "crr_map.svh"

interface crr_ser_if;
  logic                      rise;
  logic                      fall;
  logic                      load;
  logic                      fwd;
  logic [`CRR_BYTE_BITS-1:0] data;
  logic                      dout;

  modport src (output rise, output fall, output load, output fwd, output data, input dout);
  modport snk (input rise, input fall, input load, input fwd, input data, output dout);
endinterface

/* File: hw/crr_serializer.sv */
/*
  Chain serializer: turns captured ROM bytes into the downstream bit stream.
  Assumes rise/fall are one-cycle marks of the generated configuration clock.
*/
`include "crr_map.svh"

module crr_serializer (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Core link
  crr_ser_if.snk    ser
);

  crr_pkg::crr_ser_st_t r;
  crr_pkg::crr_ser_st_t n;

  // ----------------------------------------------------------------------
  // Double buffer: previous byte's MSB still goes out after the next capture
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    if (ser.load) begin
      n.pend = ser.data;
      n.pfwd = ser.fwd;
      n.pval = 1'b1;
      n.page = 1'b0;
    end
    if (ser.fall) begin // R22
      if (r.pval && r.page == 1'(`CRR_LSB_FALLS - 1)) begin // R21
        n.dout = r.pfwd ? r.pend[0] : `CRR_CHAIN_IDLE; // R20
        n.sh   = r.pend >> 1;
        n.sfwd = r.pfwd;
        n.pval = 1'b0;
      end else begin
        n.dout = r.sfwd ? r.sh[0] : `CRR_CHAIN_IDLE;
        n.sh   = r.sh >> 1;
        n.page = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r      <= '0;
      r.dout <= `CRR_CHAIN_IDLE;
    end else begin
      r <= n;
    end
  end

  assign ser.dout = r.dout;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [1:0] h_falls;
  logic       h_lsb;
  logic       h_fwd;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      h_falls <= 2'h0;
      h_lsb   <= 1'b0;
      h_fwd   <= 1'b0;
    end else if (ser.load) begin
      h_falls <= 2'h0;
      h_lsb   <= ser.data[0];
      h_fwd   <= ser.fwd;
    end else if (ser.fall && h_falls != 2'h3) begin
      h_falls <= h_falls + 2'h1;
    end
  end

  AST_LSB_SECOND_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
    ser.fall && h_falls == 2'h1 && h_fwd |=> r.dout == h_lsb)
    else $error("byte lsb not on chain at second falling edge");

  AST_CHANGE_ON_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i) // R22
    $changed(r.dout) |-> $past(ser.fall))
    else $error("chain output changed off a falling edge");

  AST_STILL_ON_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i) // R22
    ser.rise |=> $stable(r.dout))
    else $error("chain output moved on a rising edge");

endmodule

/* File: verification/crr_far_side.sv */
/*
  Far side of the block: parallel ROM, readback host clock, shared done pin.
  Assumes the bench calls the host tasks and pulls the pin through ext_low_i.
*/
module crr_far_side (
  // ROM side
  input  wire logic [15:0] addr_i,
  output logic [7:0]       data_o,
  // Shared done pin
  input  wire logic        dev_oe_n_i,
  input  wire logic        ext_low_i,
  output logic             level_o,
  // Host clock
  output logic             host_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Zero LSB at address zero marks the start of the chain stream
  assign data_o  = {~addr_i[3:0], addr_i[3:0]};
  // Pulled-up wired-AND of every driver on the pin
  assign level_o = dev_oe_n_i & ~ext_low_i;
  // Stands still outside readback
  initial host_clk_o = 1'b0;
  task automatic host_rise();
    host_clk_o <= 1'b1;
    #62.5;
  endtask
  task automatic host_fall();
    host_clk_o <= 1'b0;
    #62.5;
  endtask
endmodule

/* File: verification/tb.sv */
/*
  Self-checking bench of crr_top with shortened timing parameters.
  Assumes crr_map.svh on the include path and crr_far_side compiled first.
*/
`include "crr_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, rstn_i = 1'b0, read_trigger_pin_i = 1'b0, hold_off_n_i = 1'b0;
  logic        ext_low = 1'b0, done_early_i = 1'b0, addr_down_i = 1'b0, collect = 1'b0;
  logic [1:0]  readback_perm_i = 2'h1;
  logic        pullup_opt_i = 1'b1, done_program_pin_o;
  logic [7:0]  rom_data_i;
  logic [15:0] rom_address_out_o;
  logic        readback_data_pin_o, readback_active_o, config_clock_i, config_clock_o;
  logic        config_clock_oe_n_o, done_program_pin_i, done_program_pin_oe_n_o;
  logic        done_pullup_en_o, init_done_o, rom_addr_oe_n_o, chain_data_o;
  logic        user_out_en_o, weak_pullup_o;
  logic [0:199] chain_q;
  int          nq = 0, checks = 0, n_mismatch = 0, cyc = 0;

  crr_top #(.TGEN_DIV(2), .CLEAR_TICKS(4), .CONFIG_CLOCK_HALF(2)) dut (
    .clk_i, .rstn_i, .read_trigger_pin_i, .readback_data_pin_o, .readback_active_o,
    .config_clock_i, .config_clock_o, .config_clock_oe_n_o, .done_program_pin_i,
    .done_program_pin_o, .done_program_pin_oe_n_o, .done_pullup_en_o, .init_done_o,
    .hold_off_n_i, .rom_address_out_o, .rom_addr_oe_n_o, .rom_data_i, .chain_data_o,
    .user_out_en_o, .weak_pullup_o, .readback_perm_i, .done_early_i,
    .pullup_opt_i, .addr_down_i, .live_state_i(8'h80));

  crr_far_side host (.addr_i(rom_address_out_o), .data_o(rom_data_i),
    .dev_oe_n_i(done_program_pin_oe_n_o), .ext_low_i(ext_low),
    .level_o(done_program_pin_i), .host_clk_o(config_clock_i));

  always #5 clk_i = ~clk_i;
  // Follower samples the chain on rising configuration clock
  always @(posedge config_clock_o) if (collect && config_clock_oe_n_o === 1'b0) begin
    chain_q[nq] = chain_data_o;
    nq++;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [7:0] rom(input logic [15:0] a);
    return {~a[3:0], a[3:0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_load();
    int s;
    logic [79:0] e, g;
    logic [7:0] b;
    `CHK("done drive", 1'b0, done_program_pin_oe_n_o)
    `CHK("user en", 1'b0, user_out_en_o)
    `CHK("weak pull", 1'b1, weak_pullup_o)
    `CHK("pullup opt", 1'b1, done_pullup_en_o)
    `CHK("done pin low", 1'b0, done_program_pin_o)
    collect = 1'b1;
    for (int n = 0; n < 500 && init_done_o !== 1'b1; n++) @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    `CHK("held off", 1'b1, rom_addr_oe_n_o)
    hold_off_n_i <= 1'b1;
    for (int n = 0; n < 3000 && user_out_en_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    `CHK("done late", 1'b0, done_program_pin_oe_n_o)
    collect = 1'b0;
    s = 0;
    while (s < nq - 1 && chain_q[s] !== 1'b0) s++;
    for (int j = 0; j < 80; j++) begin
      b    = rom(16'(j / 8));
      e[j] = (j / 8 >= 2 && j / 8 < 6) ? 1'b1 : b[j % 8];
      g[j] = chain_q[s + j];
    end
    `CHK("chain stream", e, g)
    `CHK("rom pins freed", 1'b1, rom_addr_oe_n_o)
  endtask

  task automatic t_readback(input logic d, input logic [1:0] p);
    logic [41:0] e, g;
    logic [7:0] b;
    e[1:0] = 2'h3;
    for (int f = 0; f < 4; f++) begin
      b = rom(d ? 16'hFFFD - 16'(f) : 16'(f + 2));
      e[2 + f * 10] = 1'b1;
      for (int i = 0; i < 8; i++) e[3 + f * 10 + i] = (i < 6) ? ~b[i] : (i == 6);
      e[11 + f * 10] = 1'b0;
    end
    @(posedge clk_i) readback_perm_i <= p;
    read_trigger_pin_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK("readback on", 1'b1, readback_active_o)
    for (int k = 0; k < 42; k++) begin
      host.host_rise();
      g[k] = readback_data_pin_o;
      host.host_fall();
    end
    host.host_rise();
    `CHK("readback bits", e, g)
    `CHK("readback off", 1'b0, readback_active_o)
    `CHK("user pins kept", 1'b1, user_out_en_o)
    host.host_fall();
    @(posedge clk_i) read_trigger_pin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_refuse(input logic [1:0] p);
    @(posedge clk_i) readback_perm_i <= p;
    read_trigger_pin_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK("readback refused", 1'b0, readback_active_o)
    read_trigger_pin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_reprogram();
    // Two clocks low: past the synchroniser, short of two generator ticks
    @(posedge clk_i) ext_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    ext_low <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK("glitch ignored", 1'b1, user_out_en_o)
    done_early_i <= 1'b1;
    pullup_opt_i <= 1'b0;
    addr_down_i <= 1'b1;
    hold_off_n_i <= 1'b0;
    ext_low <= 1'b1;
    for (int n = 0; n < 40 && done_program_pin_oe_n_o !== 1'b0; n++) @(posedge clk_i);
    #1;
    `CHK("outputs off", 1'b0, user_out_en_o)
    `CHK("pulls on", 1'b1, weak_pullup_o)
    `CHK("clearing", 1'b0, init_done_o)
    `CHK("pullup off", 1'b0, done_pullup_en_o)
    for (int n = 0; n < 500 && init_done_o !== 1'b1; n++) @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    `CHK("held off again", 1'b1, rom_addr_oe_n_o)
    `CHK("done held", 1'b0, done_program_pin_oe_n_o)
    hold_off_n_i <= 1'b1;
    for (int n = 0; n < 3000 && done_program_pin_oe_n_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    `CHK("done early", 1'b0, user_out_en_o)
    for (int n = 0; n < 100 && user_out_en_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    `CHK("operate under low", 1'b1, user_out_en_o)
    @(posedge clk_i) ext_low <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK("stays operating", 1'b1, user_out_en_o)
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_load();
    t_readback(1'b0, 2'h1);
    t_refuse(2'h1);
    t_refuse(2'h0);
    t_refuse(2'h3);
    t_readback(1'b0, 2'h2);
    t_readback(1'b0, 2'h2);
    t_reprogram();
    t_readback(1'b1, 2'h1);
    end_of_test();
  end
endmodule
